/* File: verilog/stpo_regs.sv */
// register bank: analog test-bus route select and lane power override
// assumes a classic wishbone master on i_clock; lane inputs are synchronous to i_clock
//
// Our own choice: the Wishbone register port.
module stpo_regs (
  input wire logic i_clock, // 200 MHz register clock
  input wire logic i_rst_n, // asynchronous active-low reset
  input wire logic i_wb_cyc, // wishbone cycle
  input wire logic i_wb_stb, // wishbone strobe
  input wire logic i_wb_we, // wishbone write enable
  input wire logic [11:0] i_wb_adr, // byte address
  input wire logic [3:0] i_wb_sel, // byte lane selects
  input wire logic [31:0] i_wb_dat, // write data
  output logic [31:0] o_wb_dat, // read data
  output logic o_wb_ack, // one-cycle acknowledge
  input wire logic [1:0] i_tx_en, // core transmit-enable power state
  input wire logic i_data_ovrd, // core data-override
  input wire logic i_beacon, // core beacon control
  output stpo_pkg::stpo_atb_t o_atb, // analog test switches
  output stpo_pkg::stpo_lane_t o_lane // lane controls after override
);
  stpo_pkg::stpo_state_t s_q;
  stpo_pkg::stpo_state_t s_d;
  logic req;
  logic [31:0] bmask;

  // expand byte selects into a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{sel[i]}};
    end
    return m;
  endfunction : lane_mask

  // masked write merge of one register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [31:0] m, input logic [31:0] wm);
    return ((old & ~m) | (wd & m)) & wm;
  endfunction : merge

  assign req = i_wb_cyc && i_wb_stb && !s_q.ack;
  assign bmask = lane_mask(i_wb_sel);

  // next state: bus access, then derived outputs from the stored registers
  always_comb begin
    s_d = s_q;
    s_d.ack = req;
    s_d.rdata = 32'h0000_0000;
    if (req && i_wb_we) begin
      if (i_wb_adr == stpo_pkg::ATR_OFFSET) begin
        s_d.atr = merge(s_q.atr, i_wb_dat, bmask, stpo_pkg::ATR_WMASK);
      end else if (i_wb_adr == stpo_pkg::LPO_OFFSET) begin
        s_d.lpo = merge(s_q.lpo, i_wb_dat, bmask, stpo_pkg::LPO_WMASK);
      end
    end else if (req) begin
      if (i_wb_adr == stpo_pkg::ATR_OFFSET) begin
        s_d.rdata = s_q.atr;
      end else if (i_wb_adr == stpo_pkg::LPO_OFFSET) begin
        s_d.rdata = s_q.lpo;
      end
    end
    // analog routes, gated by the bus connect bit except txm_to_sense_plus and txp_to_force_plus
    s_d.atb.bus_connect = s_q.atr[stpo_pkg::ATR_BUS_CONNECT];
    s_d.atb.rxdetect_ref_to_sense_minus = s_q.atr[stpo_pkg::ATR_RXDET_SM] &
        s_q.atr[stpo_pkg::ATR_BUS_CONNECT];
    s_d.atb.vcm_to_sense_plus = s_q.atr[stpo_pkg::ATR_VCM_SP] &
        s_q.atr[stpo_pkg::ATR_BUS_CONNECT];
    s_d.atb.erc0_to_sense_minus = s_q.atr[stpo_pkg::ATR_ERC0_SM] &
        s_q.atr[stpo_pkg::ATR_BUS_CONNECT];
    s_d.atb.erc1_to_sense_minus = s_q.atr[stpo_pkg::ATR_ERC1_SM] &
        s_q.atr[stpo_pkg::ATR_BUS_CONNECT];
    s_d.atb.erc2_to_sense_minus = s_q.atr[stpo_pkg::ATR_ERC2_SM] &
        s_q.atr[stpo_pkg::ATR_BUS_CONNECT];
    s_d.atb.erc3_to_sense_plus = s_q.atr[stpo_pkg::ATR_ERC3_SP] &
        s_q.atr[stpo_pkg::ATR_BUS_CONNECT];
    s_d.atb.txm_to_sense_minus = s_q.atr[stpo_pkg::ATR_TXM_SM] &
        s_q.atr[stpo_pkg::ATR_BUS_CONNECT];
    // termination measurement switches act without the connect bit
    s_d.atb.txm_to_sense_plus = s_q.atr[stpo_pkg::ATR_TXM_SP];
    s_d.atb.txp_to_sense_plus = s_q.atr[stpo_pkg::ATR_TXP_SP] &
        s_q.atr[stpo_pkg::ATR_BUS_CONNECT];
    s_d.atb.txp_to_force_plus = s_q.atr[stpo_pkg::ATR_TXP_FP];
    s_d.atb.regulator_out_sel = s_q.atr[stpo_pkg::ATR_REG_SM] &
        s_q.atr[stpo_pkg::ATR_BUS_CONNECT];
    s_d.atb.txref_to_sense_plus = s_q.atr[stpo_pkg::ATR_TXREF_SP] &
        s_q.atr[stpo_pkg::ATR_BUS_CONNECT];
    s_d.atb.regulator_gate_sel = s_q.atr[stpo_pkg::ATR_GATE_SP] &
        s_q.atr[stpo_pkg::ATR_BUS_CONNECT];
    // loopback enables; software keeps the two apart
    s_d.lane.tx_external_loopback_enable = s_q.atr[stpo_pkg::ATR_EXT_LPBK];
    s_d.lane.tx_internal_loopback_enable = s_q.atr[stpo_pkg::ATR_INT_LPBK];
    // override multiplexers
    s_d.lane.tx_en = s_q.lpo[stpo_pkg::LPO_PWR_FORCE] ?
        s_q.lpo[stpo_pkg::LPO_PWR_HI:stpo_pkg::LPO_PWR_LO] : i_tx_en;
    s_d.lane.data_ovrd = s_q.lpo[stpo_pkg::LPO_DO_FORCE] ?
        s_q.lpo[stpo_pkg::LPO_DO_VAL] : i_data_ovrd;
    s_d.lane.beacon = s_q.lpo[stpo_pkg::LPO_BCN_FORCE] ?
        s_q.lpo[stpo_pkg::LPO_BCN_VAL] : i_beacon;
  end

  // state register, all zero at reset
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_wb_ack = s_q.ack;
  assign o_wb_dat = s_q.rdata;
  assign o_atb = s_q.atb;
  assign o_lane = s_q.lane;

  // write to the route register lands one edge later
  a_atr_write: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    req && i_wb_we && i_wb_adr == stpo_pkg::ATR_OFFSET && (&i_wb_sel) |=>
    s_q.atr == ($past(i_wb_dat) & stpo_pkg::ATR_WMASK)) else $error("route write lost");
  a_lpo_write: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    req && i_wb_we && i_wb_adr == stpo_pkg::LPO_OFFSET && (&i_wb_sel) |=>
    s_q.lpo == ($past(i_wb_dat) & stpo_pkg::LPO_WMASK)) else $error("override write lost");
  a_ack_pulse: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_wb_ack |=> !o_wb_ack) else $error("ack longer than one cycle");
  a_ack_follows: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("request not acked");
  a_route_gated: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !s_q.atr[stpo_pkg::ATR_BUS_CONNECT] |=> !o_atb.rxdetect_ref_to_sense_minus &&
    !o_atb.erc0_to_sense_minus && !o_atb.regulator_gate_sel) else $error("route without bus");
  a_bus_connect: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    s_q.atr[stpo_pkg::ATR_BUS_CONNECT] |=> o_atb.bus_connect) else $error("bus not joined");
  a_pwr_force: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    s_q.lpo[stpo_pkg::LPO_PWR_FORCE] |=>
    o_lane.tx_en == $past(s_q.lpo[stpo_pkg::LPO_PWR_HI:stpo_pkg::LPO_PWR_LO]))
    else $error("power force wrong");
  a_pwr_pass: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !s_q.lpo[stpo_pkg::LPO_PWR_FORCE] |=> o_lane.tx_en == $past(i_tx_en))
    else $error("power passthrough wrong");
  a_do_force: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    1'b1 |=> o_lane.data_ovrd == ($past(s_q.lpo[stpo_pkg::LPO_DO_FORCE]) ?
    $past(s_q.lpo[stpo_pkg::LPO_DO_VAL]) : $past(i_data_ovrd))) else $error("dataovrd wrong");
  a_bcn_force: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    1'b1 |=> o_lane.beacon == ($past(s_q.lpo[stpo_pkg::LPO_BCN_FORCE]) ?
    $past(s_q.lpo[stpo_pkg::LPO_BCN_VAL]) : $past(i_beacon))) else $error("beacon wrong");
  a_lpbk_track: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    1'b1 |=> o_lane.tx_internal_loopback_enable == $past(s_q.atr[stpo_pkg::ATR_INT_LPBK]))
    else $error("loopback wrong");
  a_reserved_zero: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (s_q.atr & ~stpo_pkg::ATR_WMASK) == 32'h0000_0000 &&
    (s_q.lpo & ~stpo_pkg::LPO_WMASK) == 32'h0000_0000) else $error("reserved bits set");

  // per-switch checks: gated routes follow their bit only with the bus joined
  // rx-detect reference onto sense-minus
  a_rxdet_route: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    1'b1 |=> o_atb.rxdetect_ref_to_sense_minus ==
    ($past(s_q.atr[stpo_pkg::ATR_RXDET_SM]) && $past(s_q.atr[stpo_pkg::ATR_BUS_CONNECT])))
    else $error("rx-detect route wrong");
  // common-mode replica onto sense-plus
  a_vcm_route: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    1'b1 |=> o_atb.vcm_to_sense_plus ==
    ($past(s_q.atr[stpo_pkg::ATR_VCM_SP]) && $past(s_q.atr[stpo_pkg::ATR_BUS_CONNECT])))
    else $error("common-mode route wrong");
  // first edge-rate bias onto sense-minus
  a_erc0_route: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    1'b1 |=> o_atb.erc0_to_sense_minus ==
    ($past(s_q.atr[stpo_pkg::ATR_ERC0_SM]) && $past(s_q.atr[stpo_pkg::ATR_BUS_CONNECT])))
    else $error("bias zero route wrong");
  // second edge-rate bias onto sense-minus
  a_erc1_route: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    1'b1 |=> o_atb.erc1_to_sense_minus ==
    ($past(s_q.atr[stpo_pkg::ATR_ERC1_SM]) && $past(s_q.atr[stpo_pkg::ATR_BUS_CONNECT])))
    else $error("bias one route wrong");
  // third edge-rate bias onto sense-minus
  a_erc2_route: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    1'b1 |=> o_atb.erc2_to_sense_minus ==
    ($past(s_q.atr[stpo_pkg::ATR_ERC2_SM]) && $past(s_q.atr[stpo_pkg::ATR_BUS_CONNECT])))
    else $error("bias two route wrong");
  // fourth edge-rate bias onto sense-plus
  a_erc3_route: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    1'b1 |=> o_atb.erc3_to_sense_plus ==
    ($past(s_q.atr[stpo_pkg::ATR_ERC3_SP]) && $past(s_q.atr[stpo_pkg::ATR_BUS_CONNECT])))
    else $error("bias three route wrong");
  // negative tx onto sense-minus
  a_txm_minus: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    1'b1 |=> o_atb.txm_to_sense_minus ==
    ($past(s_q.atr[stpo_pkg::ATR_TXM_SM]) && $past(s_q.atr[stpo_pkg::ATR_BUS_CONNECT])))
    else $error("negative tx route wrong");
  // negative tx onto sense-plus, not gated for termination measurement
  a_txm_plus: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    1'b1 |=> o_atb.txm_to_sense_plus == $past(s_q.atr[stpo_pkg::ATR_TXM_SP]))
    else $error("negative tx termination route wrong");
  // positive tx onto sense-plus
  a_txp_plus: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    1'b1 |=> o_atb.txp_to_sense_plus ==
    ($past(s_q.atr[stpo_pkg::ATR_TXP_SP]) && $past(s_q.atr[stpo_pkg::ATR_BUS_CONNECT])))
    else $error("positive tx route wrong");
  // positive tx onto force-plus, not gated for termination measurement
  a_txp_force: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    1'b1 |=> o_atb.txp_to_force_plus == $past(s_q.atr[stpo_pkg::ATR_TXP_FP]))
    else $error("positive tx force route wrong");
  // regulator output onto sense-minus
  a_regout_route: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    1'b1 |=> o_atb.regulator_out_sel ==
    ($past(s_q.atr[stpo_pkg::ATR_REG_SM]) && $past(s_q.atr[stpo_pkg::ATR_BUS_CONNECT])))
    else $error("regulator route wrong");
  // transmit reference onto sense-plus
  a_txref_route: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    1'b1 |=> o_atb.txref_to_sense_plus ==
    ($past(s_q.atr[stpo_pkg::ATR_TXREF_SP]) && $past(s_q.atr[stpo_pkg::ATR_BUS_CONNECT])))
    else $error("reference route wrong");
  // regulator gate onto sense-plus
  a_gate_route: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    1'b1 |=> o_atb.regulator_gate_sel ==
    ($past(s_q.atr[stpo_pkg::ATR_GATE_SP]) && $past(s_q.atr[stpo_pkg::ATR_BUS_CONNECT])))
    else $error("gate route wrong");
  // bus stays apart while the connect bit is clear
  a_bus_open: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !s_q.atr[stpo_pkg::ATR_BUS_CONNECT] |=> !o_atb.bus_connect)
    else $error("bus joined without connect bit");
  // external loopback follows its bit
  a_ext_lpbk: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    1'b1 |=> o_lane.tx_external_loopback_enable == $past(s_q.atr[stpo_pkg::ATR_EXT_LPBK]))
    else $error("external loopback wrong");
  // register side checks
  // route register read returns the stored value in the ack cycle
  a_atr_read: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    req && !i_wb_we && i_wb_adr == stpo_pkg::ATR_OFFSET |=>
    o_wb_dat == $past(s_q.atr))
    else $error("route read wrong");
  // override register read returns the stored value in the ack cycle
  a_lpo_read: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    req && !i_wb_we && i_wb_adr == stpo_pkg::LPO_OFFSET |=>
    o_wb_dat == $past(s_q.lpo))
    else $error("override read wrong");
  // read data is zero outside the ack cycle
  a_idle_data: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !o_wb_ack |-> o_wb_dat == 32'h0000_0000)
    else $error("read data outside ack");
  // unmapped reads return zero
  a_unmapped_read: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    req && !i_wb_we && i_wb_adr != stpo_pkg::ATR_OFFSET && i_wb_adr != stpo_pkg::LPO_OFFSET
    |=> o_wb_dat == 32'h0000_0000)
    else $error("unmapped read not zero");
  // unmapped writes change nothing
  a_unmapped_write: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    req && i_wb_we && i_wb_adr != stpo_pkg::ATR_OFFSET && i_wb_adr != stpo_pkg::LPO_OFFSET
    |=> s_q.atr == $past(s_q.atr) && s_q.lpo == $past(s_q.lpo))
    else $error("unmapped write landed");
  // registers hold without a write request
  a_regs_hold: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !(req && i_wb_we) |=> s_q.atr == $past(s_q.atr) && s_q.lpo == $past(s_q.lpo))
    else $error("register changed without write");
  // a write with no lane selected changes nothing
  a_sel_none: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    req && i_wb_we && i_wb_sel == 4'h0 |=>
    s_q.atr == $past(s_q.atr) && s_q.lpo == $past(s_q.lpo))
    else $error("write without lanes landed");
  // low byte of the route register kept when its lane is off
  a_atr_lane0: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    req && i_wb_we && !i_wb_sel[0] |=> s_q.atr[7:0] == $past(s_q.atr[7:0]))
    else $error("route low byte written");
  // third byte of the route register kept when its lane is off
  a_atr_lane2: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    req && i_wb_we && !i_wb_sel[2] |=> s_q.atr[23:16] == $past(s_q.atr[23:16]))
    else $error("route third byte written");
  // override register kept when its lane is off
  a_lpo_lane0: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    req && i_wb_we && !i_wb_sel[0] |=> s_q.lpo[7:0] == $past(s_q.lpo[7:0]))
    else $error("override byte written");
  // ack only answers a request
  a_ack_cause: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !(i_wb_cyc && i_wb_stb) |=> !o_wb_ack)
    else $error("ack without request");
  // no ack while the cycle is down
  a_ack_idle: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !i_wb_cyc |=> !o_wb_ack)
    else $error("ack outside cycle");
  // switches stand while the route register stands
  a_atb_stable: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $stable(s_q.atr) |=> $stable(o_atb))
    else $error("switch moved without register change");
  // power, data-override and beacon controls stand while the override register and inputs stand
  a_lane_stable: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $stable(s_q.lpo) && $stable(i_tx_en) && $stable(i_data_ovrd) && $stable(i_beacon)
    |=> $stable(o_lane[5:2]))
    else $error("lane control moved without cause");
  // a held strobe after ack does not write again
  a_no_rewrite: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_wb_cyc && i_wb_stb && s_q.ack |=>
    s_q.atr == $past(s_q.atr) && s_q.lpo == $past(s_q.lpo))
    else $error("second write in ack cycle");

  c_ext_loopback: cover property (@(posedge i_clock) disable iff (!i_rst_n)
    o_lane.tx_external_loopback_enable);
  c_route_on: cover property (@(posedge i_clock) disable iff (!i_rst_n)
    o_atb.bus_connect && o_atb.txp_to_sense_plus);
  c_pwr_forced: cover property (@(posedge i_clock) disable iff (!i_rst_n)
    s_q.lpo[stpo_pkg::LPO_PWR_FORCE] && o_lane.tx_en == stpo_pkg::PWR_IDLE_FAST);
  c_read_ack: cover property (@(posedge i_clock) disable iff (!i_rst_n)
    o_wb_ack && o_wb_dat != 32'h0000_0000);
  c_beacon_forced: cover property (@(posedge i_clock) disable iff (!i_rst_n)
    s_q.lpo[stpo_pkg::LPO_BCN_FORCE] && o_lane.beacon);
endmodule : stpo_regs

/* File: verilog/stpo_pkg.sv */
// package for the lane test-bus and power override register bank
// assumes a 32-bit classic wishbone register host on one clock
package stpo_pkg;
  // register byte offsets
  localparam logic [11:0] ATR_OFFSET = 12'h068;
  localparam logic [11:0] LPO_OFFSET = 12'h06c;
  localparam logic [31:0] ATR_RESET = 32'h0000_0000;
  localparam logic [31:0] LPO_RESET = 32'h0000_0000;
  // writable bit masks, reserved bits read zero
  localparam logic [31:0] ATR_WMASK = 32'h00ff_00ff;
  localparam logic [31:0] LPO_WMASK = 32'h0000_00ff;
  // test-route field positions
  localparam int ATR_BUS_CONNECT = 23;
  localparam int ATR_RXDET_SM = 22;
  localparam int ATR_VCM_SP = 21;
  localparam int ATR_ERC0_SM = 20;
  localparam int ATR_ERC1_SM = 19;
  localparam int ATR_ERC2_SM = 18;
  localparam int ATR_EXT_LPBK = 17;
  localparam int ATR_INT_LPBK = 16;
  localparam int ATR_ERC3_SP = 7;
  localparam int ATR_TXM_SM = 6;
  localparam int ATR_TXM_SP = 5;
  localparam int ATR_TXP_SP = 4;
  localparam int ATR_TXP_FP = 3;
  localparam int ATR_REG_SM = 2;
  localparam int ATR_TXREF_SP = 1;
  localparam int ATR_GATE_SP = 0;
  // power override field positions
  localparam int LPO_PWR_FORCE = 7;
  localparam int LPO_PWR_HI = 6;
  localparam int LPO_PWR_LO = 5;
  localparam int LPO_DO_FORCE = 4;
  localparam int LPO_DO_VAL = 3;
  localparam int LPO_BCN_FORCE = 2;
  localparam int LPO_BCN_VAL = 1;
  // power state encodings
  localparam logic [1:0] PWR_OFF = 2'h0;
  localparam logic [1:0] PWR_IDLE_SLOW = 2'h1;
  localparam logic [1:0] PWR_TX_DATA = 2'h2;
  localparam logic [1:0] PWR_IDLE_FAST = 2'h3;
  // analog switch controls
  typedef struct packed {
    logic bus_connect;
    logic rxdetect_ref_to_sense_minus;
    logic vcm_to_sense_plus;
    logic erc0_to_sense_minus;
    logic erc1_to_sense_minus;
    logic erc2_to_sense_minus;
    logic erc3_to_sense_plus;
    logic txm_to_sense_minus;
    logic txm_to_sense_plus;
    logic txp_to_sense_plus;
    logic txp_to_force_plus;
    logic regulator_out_sel;
    logic txref_to_sense_plus;
    logic regulator_gate_sel;
  } stpo_atb_t;
  // lane control values after override
  typedef struct packed {
    logic [1:0] tx_en;
    logic data_ovrd;
    logic beacon;
    logic tx_external_loopback_enable;
    logic tx_internal_loopback_enable;
  } stpo_lane_t;
  // whole state of the bank
  typedef struct packed {
    logic [31:0] atr;
    logic [31:0] lpo;
    logic ack;
    logic [31:0] rdata;
    stpo_atb_t atb;
    stpo_lane_t lane;
  } stpo_state_t;
endpackage : stpo_pkg

/* File: dv/stpo_regs_tb.sv */
// testbench for the lane test-bus and power override register bank
// assumes stpo_pkg and stpo_regs are compiled first; assertions live in the design
module serdes_test_power_override_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic [1:0] tx_en = 2'h0;
  logic dovr = 1'b0;
  logic bcn = 1'b0;
  stpo_pkg::stpo_atb_t atb;
  stpo_pkg::stpo_lane_t lane;
  int n_fail = 0;
  int n_checks = 0;
  stpo_regs dut (.i_clock(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_tx_en(tx_en), .i_data_ovrd(dovr), .i_beacon(bcn), .o_atb(atb), .o_lane(lane));
  // 200 MHz clock
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  // one classic wishbone cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [11:0] a, input logic [3:0] s,
    input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    if (n >= 50) begin
      n_fail++;
      $display("ERROR %0t no acknowledge within bound", $time);
      finish_test();
    end else begin
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk);
    end
  endtask : wb
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    logic [31:0] q;
    wb(1'b1, a, s, d, q);
    repeat (3) @(posedge clk);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string what);
    logic [31:0] q;
    wb(1'b0, a, 4'hf, 32'h0, q);
    chk(q, e, what);
  endtask : rd
  // lane outputs after override, loopbacks left out
  task automatic chk_lane(input logic [3:0] e, input string what);
    chk({28'h0, lane[5:2]}, {28'h0, e}, what);
  endtask : chk_lane
  task automatic t_route();
    int pos[13] = '{22, 21, 20, 19, 18, 7, 6, 5, 4, 3, 2, 1, 0};
    rd(stpo_pkg::ATR_OFFSET, 32'h0, "route reset");
    rd(stpo_pkg::LPO_OFFSET, 32'h0, "override reset");
    chk({18'h0, atb}, 32'h0, "switches reset");
    wr(stpo_pkg::ATR_OFFSET, 32'hffff_ffff);
    rd(stpo_pkg::ATR_OFFSET, 32'h00ff_00ff, "route reserved");
    chk({18'h0, atb}, 32'h3fff, "all switches");
    wr(stpo_pkg::ATR_OFFSET, 32'h007f_00ff);
    chk({18'h0, atb}, 32'h0028, "switches gated");
    chk({30'h0, lane[1:0]}, 32'h3, "both loopbacks");
    wr(stpo_pkg::ATR_OFFSET, 32'h0002_0000);
    chk({30'h0, lane[1:0]}, 32'h2, "external loopback");
    wr(stpo_pkg::ATR_OFFSET, 32'h0001_0000);
    chk({30'h0, lane[1:0]}, 32'h1, "internal loopback");
    // each route bit alone, with the bus connected
    for (int i = 0; i < 13; i++) begin
      wr(stpo_pkg::ATR_OFFSET, 32'h0080_0000 | (32'h1 << pos[i]));
      chk({18'h0, atb}, 32'h2000 | (32'h1 << (12 - i)), "single route");
    end
    $display("test route done");
  endtask : t_route
  task automatic t_power();
    for (int c = 0; c < 4; c++) begin
      tx_en <= ~c[1:0];
      wr(stpo_pkg::LPO_OFFSET, 32'h80 | (c << 5));
      chk_lane({c[1:0], 2'b00}, "forced power state");
    end
    tx_en <= 2'h2;
    wr(stpo_pkg::LPO_OFFSET, 32'h0000_0060);
    chk_lane(4'h8, "power state follows input");
    wr(stpo_pkg::LPO_OFFSET, 32'h0000_001e);
    chk_lane(4'hb, "data and beacon forced high");
    dovr <= 1'b1;
    bcn <= 1'b1;
    wr(stpo_pkg::LPO_OFFSET, 32'h0000_0014);
    chk_lane(4'h8, "data and beacon forced low");
    dovr <= 1'b0;
    bcn <= 1'b0;
    wr(stpo_pkg::LPO_OFFSET, 32'h0000_000a);
    chk_lane(4'h8, "local values without force");
    wr(stpo_pkg::LPO_OFFSET, 32'hffff_ffff);
    rd(stpo_pkg::LPO_OFFSET, 32'h0000_00ff, "override reserved");
    wr(stpo_pkg::LPO_OFFSET, 32'h0000_0000, 4'he);
    rd(stpo_pkg::LPO_OFFSET, 32'h0000_00ff, "lane not selected");
    wr(12'h070, 32'hffff_ffff);
    rd(12'h070, 32'h0, "unmapped read");
    $display("test power done");
  endtask : t_power
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_route();
    t_power();
    finish_test();
  end
endmodule : serdes_test_power_override_tb_top
